// >>> fg_prog_pkg.sv
// constants, register layout and instruction codes of the floating gate programmer
// ****************************************
// Functional notes
// - code 0 selects readout mode, routes one cell out until another instruction
// - code 1 programs the addressed line upward
// - code 2 programs the addressed line downward
// - code 3 finds next failed cell and reports its column
// - code 4 plays one RAM bank once, stops at last address
// - code 5 plays one RAM bank repeatedly until another instruction
// - timing bits 7:0 limit programming cycles per run
// - verification reads wait the settling time before sampling
// - settling time is timing bits 13:8
// - write pulse time doubles after timing bits 19:14 cycles
// - voltage pulse bits 25:20, current pulse bits 31:26
// - bias bits 3:0 upper voltage, bits 7:4 follower bias, zero is maximum
// - bias bits 11:8 set internal clock to system clock ratio
// - bias bit 12 shorts membrane, bit 13 enables calibration
// - command holds line 4:0, column 12:5, bank 13, instruction 16:14
// - result bits 7:0 give failed cell column
// - result bit 8 high while programming machine is active
// - result bit 9 set when any cell missed its target
// ****************************************
package fg_prog_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [2:0] bias_addr = 3'h0;
  localparam logic [2:0] timing_addr = 3'h1;
  localparam logic [2:0] command_addr = 3'h2;
  localparam logic [2:0] result_addr = 3'h3;
  localparam logic [2:0] irq_status_addr = 3'h4;
  localparam logic [2:0] irq_mask_addr = 3'h5;
  localparam logic [13:0] bias_reset = 14'h0000;
  localparam logic [31:0] timing_reset = 32'h0000_0000;
  localparam logic [16:0] command_reset = 17'h00000;
  // ****************************************
  // field positions
  // ****************************************
  localparam int max_cycle_lsb = 0;
  localparam int read_time_lsb = 8;
  localparam int pulse_doubling_interval_lsb = 14;
  localparam int voltage_time_lsb = 20;
  localparam int current_time_lsb = 26;
  localparam int upper_prog_bias_lsb = 0;
  localparam int follower_bias_lsb = 4;
  localparam int clock_ratio_lsb = 8;
  localparam int membrane_short_bit = 12;
  localparam int calib_bit = 13;
  localparam int line_index_lsb = 0;
  localparam int column_index_lsb = 5;
  localparam int ram_bank_select_bit = 13;
  localparam int instr_lsb = 14;
  localparam int busy_bit = 8;
  localparam int error_bit = 9;
  // irq bits: 0 run done, 1 cell failed
  localparam int irq_done_bit = 0;
  localparam int irq_fail_bit = 1;
  localparam logic [1:0] irq_reset = 2'h0;
  typedef enum logic [2:0] {
    op_read = 3'h0,
    op_program_line_up = 3'h1,
    op_program_line_down = 3'h2,
    op_find_next_failed_cell = 3'h3,
    op_stimulus_single_pass = 3'h4,
    op_stimulus_continuous = 3'h5
  } instr_t;
endpackage

// >>> fg_clk_divider.sv
// tick generator for the controller's internal clock ratio
`timescale 1ns/10ps
`default_nettype none
module fg_clk_divider (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic [3:0] ratio,
  output logic tick
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  always_comb begin
    // ratio zero ticks every clock, so the controller never freezes
    if (cnt_reg >= ratio) begin
      cnt_next = 4'h0;
    end else begin
      cnt_next = cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign tick = (cnt_reg >= ratio);
endmodule
`default_nettype wire

// >>> fg_stim_ram.sv
// two-bank stimulus memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module fg_stim_ram #(
  parameter int addr_w = 6,
  parameter int data_w = 10
) (
  // clock
  input wire logic sys_clk,
  // write side
  input wire logic wr_en,
  input wire logic [addr_w:0] wr_addr,
  input wire logic [data_w-1:0] wr_data,
  // read side
  input wire logic [addr_w:0] rd_addr,
  output logic [data_w-1:0] rd_data
);
  logic [data_w-1:0] mem [0:(2**(addr_w+1))-1];
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// >>> fg_programmer.sv
// floating gate programming controller with register port and stimulus player
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module fg_programmer
  import fg_prog_pkg::*;
#(
  parameter int ram_addr_w = 6,
  parameter int ram_data_w = 10
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // stimulus ram load port
  input wire logic ram_wr,
  input wire logic [ram_addr_w:0] ram_wr_addr,
  input wire logic [ram_data_w-1:0] ram_wr_data,
  // analog array control
  output logic [4:0] line_sel,
  output logic [7:0] column_sel,
  output logic readout_mode,
  output logic cell_route_en,
  output logic prog_up,
  output logic prog_down,
  output logic voltage_pulse,
  output logic current_pulse,
  output logic verify_sample,
  input wire logic cell_reached,
  output logic [3:0] upper_prog_bias,
  output logic [3:0] follower_bias,
  output logic membrane_short,
  output logic calib_en,
  // neuron stimulus
  output logic [ram_data_w-1:0] stim_value,
  output logic stim_valid,
  // interrupt
  output logic irq
);
  import fg_prog_pkg::*;
  typedef enum logic [2:0] {
    st_idle, st_readout, st_pulse, st_settle, st_search, st_stim
  } state_t;
  // ****************************************
  // registers
  // ****************************************
  logic [13:0] bias_reg;
  logic [31:0] timing_reg;
  logic [16:0] command_reg;
  logic [1:0] irq_status_reg, irq_status_next;
  logic [1:0] irq_mask_reg;
  logic [31:0] rdata_next;
  logic cmd_start;
  state_t state_reg, state_next;
  logic [7:0] cycle_reg, cycle_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [5:0] accel_reg, accel_next;
  logic [1:0] shift_reg, shift_next;
  logic [127:0] fail_map_reg, fail_map_next;
  logic [7:0] col_reg, col_next;
  logic [7:0] failed_column_reg, failed_column_next;
  logic error_reg, error_next;
  logic [ram_addr_w-1:0] stim_addr_reg, stim_addr_next;
  logic stim_valid_reg, stim_valid_next;
  logic phase_reg, phase_next;
  logic done_evt, fail_evt;
  logic tick;
  logic [ram_data_w-1:0] ram_rd_data;
  instr_t instr;
  logic busy;
  function automatic logic [7:0] pulse_len(input logic [5:0] base, input logic [1:0] sh);
    pulse_len = 8'({2'h0, base} << sh);
  endfunction
  assign instr = instr_t'(command_reg[instr_lsb +: 3]);
  assign cmd_start = reg_wr && (reg_addr == command_addr);
  assign busy = (state_reg != st_idle) && (state_reg != st_readout);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_reg <= bias_reset;
      timing_reg <= timing_reset;
      command_reg <= command_reset;
      irq_mask_reg <= irq_reset;
    end else if (reg_wr) begin
      if (reg_addr == bias_addr) bias_reg <= reg_wdata[13:0];
      if (reg_addr == timing_addr) timing_reg <= reg_wdata;
      if (reg_addr == command_addr) command_reg <= reg_wdata[16:0];
      if (reg_addr == irq_mask_addr) irq_mask_reg <= reg_wdata[1:0];
    end
  end
  // ****************************************
  // static outputs
  // ****************************************
  assign upper_prog_bias = bias_reg[upper_prog_bias_lsb +: 4];
  assign follower_bias = bias_reg[follower_bias_lsb +: 4];
  assign membrane_short = bias_reg[membrane_short_bit];
  assign calib_en = bias_reg[calib_bit];
  assign line_sel = command_reg[line_index_lsb +: 5];
  fg_clk_divider u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ratio(bias_reg[clock_ratio_lsb +: 4]),
    .tick(tick)
  );
  fg_stim_ram #(.addr_w(ram_addr_w), .data_w(ram_data_w)) u_ram (
    .sys_clk(sys_clk),
    .wr_en(ram_wr),
    .wr_addr(ram_wr_addr),
    .wr_data(ram_wr_data),
    .rd_addr({command_reg[ram_bank_select_bit], stim_addr_reg}),
    .rd_data(ram_rd_data)
  );
  // ****************************************
  // programming state machine
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cycle_next = cycle_reg;
    cnt_next = cnt_reg;
    accel_next = accel_reg;
    shift_next = shift_reg;
    fail_map_next = fail_map_reg;
    col_next = col_reg;
    failed_column_next = failed_column_reg;
    error_next = error_reg;
    stim_addr_next = stim_addr_reg;
    stim_valid_next = 1'b0;
    phase_next = phase_reg;
    done_evt = 1'b0;
    fail_evt = 1'b0;
    if (cmd_start) begin
      cycle_next = 8'h0;
      accel_next = 6'h0;
      shift_next = 2'h0;
      cnt_next = 8'h0;
      phase_next = 1'b0;
      stim_addr_next = '0;
      col_next = reg_wdata[column_index_lsb +: 8];
      unique case (reg_wdata[instr_lsb +: 3])
        3'h0: state_next = st_readout;
        3'h1, 3'h2: begin
          state_next = st_pulse;
          fail_map_next = '0;
          error_next = 1'b0;
        end
        3'h3: state_next = st_search;
        3'h4, 3'h5: state_next = st_stim;
        default: state_next = st_idle;
      endcase
    end else if (tick) begin
      unique case (state_reg)
        st_idle, st_readout: begin
        end
        st_pulse: begin
          // voltage phase then current phase, each stretched by the doubling shift
          if (cnt_reg + 8'h1 >= pulse_len(phase_reg ? timing_reg[current_time_lsb +: 6]
              : timing_reg[voltage_time_lsb +: 6], shift_reg)) begin
            cnt_next = 8'h0;
            if (phase_reg) begin
              phase_next = 1'b0;
              state_next = st_settle;
            end else begin
              phase_next = 1'b1;
            end
          end else begin
            cnt_next = cnt_reg + 8'h1;
          end
        end
        st_settle: begin
          if (cnt_reg >= {2'h0, timing_reg[read_time_lsb +: 6]}) begin
            cnt_next = 8'h0;
            cycle_next = cycle_reg + 8'h1;
            if (accel_reg + 6'h1 >= timing_reg[pulse_doubling_interval_lsb +: 6]) begin
              accel_next = 6'h0;
              if (shift_reg != 2'h3) shift_next = shift_reg + 2'h1;
            end else begin
              accel_next = accel_reg + 6'h1;
            end
            if (cell_reached) begin
              state_next = st_idle;
              done_evt = 1'b1;
            end else if (cycle_reg + 8'h1 >= timing_reg[max_cycle_lsb +: 8]) begin
              state_next = st_idle;
              done_evt = 1'b1;
              fail_evt = 1'b1;
              error_next = 1'b1;
              fail_map_next[col_reg[6:0]] = 1'b1;
              failed_column_next = col_reg;
            end else begin
              state_next = st_pulse;
            end
          end else begin
            cnt_next = cnt_reg + 8'h1;
          end
        end
        st_search: begin
          // one column per tick, wraps over the whole map once
          if (fail_map_reg[col_reg[6:0]]) begin
            failed_column_next = {1'b0, col_reg[6:0]};
            fail_map_next[col_reg[6:0]] = 1'b0;
            state_next = st_idle;
            done_evt = 1'b1;
          end else if (cnt_reg == 8'h7f) begin
            state_next = st_idle;
            done_evt = 1'b1;
          end else begin
            cnt_next = cnt_reg + 8'h1;
            // stay inside the 128-entry map so a wrapped hit reports a real column
            col_next = {1'b0, col_reg[6:0] + 7'h1};
          end
        end
        st_stim: begin
          stim_valid_next = 1'b1;
          stim_addr_next = stim_addr_reg + ram_addr_w'(1);
          if (&stim_addr_reg && (instr == op_stimulus_single_pass)) begin
            state_next = st_idle;
            done_evt = 1'b1;
          end
        end
        default: state_next = st_idle;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= st_idle;
      cycle_reg <= 8'h0;
      cnt_reg <= 8'h0;
      accel_reg <= 6'h0;
      shift_reg <= 2'h0;
      fail_map_reg <= '0;
      col_reg <= 8'h0;
      failed_column_reg <= 8'h0;
      error_reg <= 1'b0;
      stim_addr_reg <= '0;
      stim_valid_reg <= 1'b0;
      phase_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cycle_reg <= cycle_next;
      cnt_reg <= cnt_next;
      accel_reg <= accel_next;
      shift_reg <= shift_next;
      fail_map_reg <= fail_map_next;
      col_reg <= col_next;
      failed_column_reg <= failed_column_next;
      error_reg <= error_next;
      stim_addr_reg <= stim_addr_next;
      stim_valid_reg <= stim_valid_next;
      phase_reg <= phase_next;
    end
  end
  // ****************************************
  // array and stimulus outputs
  // ****************************************
  assign column_sel = col_reg;
  assign readout_mode = (state_reg == st_readout);
  assign cell_route_en = (state_reg == st_readout);
  assign prog_up = (state_reg == st_pulse) && (instr == op_program_line_up);
  assign prog_down = (state_reg == st_pulse) && (instr == op_program_line_down);
  assign voltage_pulse = (state_reg == st_pulse) && !phase_reg;
  assign current_pulse = (state_reg == st_pulse) && phase_reg;
  assign verify_sample = (state_reg == st_settle) && tick
    && (cnt_reg >= {2'h0, timing_reg[read_time_lsb +: 6]});
  assign stim_value = ram_rd_data;
  assign stim_valid = stim_valid_reg;
  // ****************************************
  // interrupts and read port
  // ****************************************
  always_comb begin
    irq_status_next = irq_status_reg;
    if (reg_wr && (reg_addr == irq_status_addr)) begin
      irq_status_next = irq_status_reg & ~reg_wdata[1:0];
    end
    // set wins over a clear in the same cycle
    if (done_evt) irq_status_next[irq_done_bit] = 1'b1;
    if (fail_evt) irq_status_next[irq_fail_bit] = 1'b1;
    rdata_next = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        bias_addr: rdata_next = {18'h0, bias_reg};
        timing_addr: rdata_next = timing_reg;
        command_addr: rdata_next = {15'h0, command_reg};
        result_addr: rdata_next = {22'h0, error_reg, busy, failed_column_reg};
        irq_status_addr: rdata_next = {30'h0, irq_status_reg};
        irq_mask_addr: rdata_next = {30'h0, irq_mask_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= irq_reset;
      reg_rdata <= 32'h0;
    end else begin
      irq_status_reg <= irq_status_next;
      reg_rdata <= rdata_next;
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);
  // ****************************************
  // checks
  // ****************************************
  a_busy_matches_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == result_addr |=> reg_rdata[busy_bit] == $past(busy))
    else $error("busy bit does not follow state");
  a_readout_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    readout_mode && !cmd_start |=> readout_mode)
    else $error("readout dropped without new instruction");
  a_cycle_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busy && (instr == op_program_line_up || instr == op_program_line_down)
    && timing_reg[7:0] != 8'h0 |-> cycle_reg < timing_reg[7:0])
    else $error("programming exceeded cycle limit");
  a_error_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    error_reg && !cmd_start |=> error_reg)
    else $error("error flag lost");
  a_fail_sets_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fail_evt |=> error_reg && irq_status_reg[irq_fail_bit])
    else $error("failure not reported");
  a_up_down_excl: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(prog_up && prog_down))
    else $error("both program directions active");
  a_single_pass_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == st_stim && instr == op_stimulus_single_pass && tick && !cmd_start
    && &stim_addr_reg |=> state_reg == st_idle)
    else $error("single pass did not stop at last address");
  a_continuous_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == st_stim && instr == op_stimulus_continuous && !cmd_start
    |=> state_reg == st_stim)
    else $error("continuous stimulus stopped");
  // settle age counts raw clocks, so the check does not lean on the tick counter
  logic [7:0] settle_age_reg, settle_age_next;
  always_comb begin
    settle_age_next = 8'h0;
    if (state_reg == st_settle) begin
      settle_age_next = (settle_age_reg == 8'hff) ? settle_age_reg : settle_age_reg + 8'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_age_reg <= 8'h0;
    end else begin
      settle_age_reg <= settle_age_next;
    end
  end
  a_verify_waits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    verify_sample |-> settle_age_reg >= {2'h0, timing_reg[read_time_lsb +: 6]})
    else $error("sample taken before settling");
endmodule
`default_nettype wire

// >>> fg_array_model.sv
// behavioural floating gate array and neuron input model
`timescale 1ns/10ps
`default_nettype none
module fg_array_model (
  // clock and test control
  input wire logic sys_clk,
  input wire logic restart,
  input wire logic [7:0] need,
  // array side
  input wire logic prog_up,
  input wire logic prog_down,
  input wire logic voltage_pulse,
  input wire logic current_pulse,
  input wire logic verify_sample,
  output logic cell_reached,
  // neuron side
  input wire logic stim_valid,
  input wire logic [9:0] stim_value,
  // observations
  output logic [7:0] n_verify,
  output logic [15:0] n_up,
  output logic [15:0] n_down,
  output logic [7:0] v_first,
  output logic [7:0] v_last,
  output logic [7:0] c_first,
  output logic [7:0] gap_min,
  output logic [15:0] n_stim,
  output logic [9:0] stim_last
);
  logic [7:0] v_run = 8'h00;
  logic [7:0] c_run = 8'h00;
  logic [7:0] gap = 8'h00;
  logic noise = 1'b0;
  // ****************
  // cell level
  // ****************
  // need of zero never reaches; off the sample cycle the level toggles so a stray read shows
  assign cell_reached = verify_sample ? (need != 8'h00 && n_verify + 8'h01 >= need) : noise;
  always @(posedge sys_clk) begin
    noise <= ~noise;
    v_run <= voltage_pulse ? v_run + 8'h01 : 8'h00;
    c_run <= current_pulse ? c_run + 8'h01 : 8'h00;
    gap <= current_pulse ? 8'h00 : gap + 8'h01;
    if (restart) begin
      n_verify <= 8'h00;
      n_up <= 16'h0000;
      n_down <= 16'h0000;
      v_first <= 8'h00;
      v_last <= 8'h00;
      c_first <= 8'h00;
      gap_min <= 8'hff;
      n_stim <= 16'h0000;
      stim_last <= 10'h000;
    end else begin
      if (verify_sample) begin
        n_verify <= n_verify + 8'h01;
        if (gap < gap_min) gap_min <= gap;
      end
      n_up <= n_up + {15'h0000, prog_up};
      n_down <= n_down + {15'h0000, prog_down};
      if (!voltage_pulse && v_run != 8'h00) begin
        v_last <= v_run;
        if (v_first == 8'h00) v_first <= v_run;
      end
      if (!current_pulse && c_run != 8'h00 && c_first == 8'h00) c_first <= c_run;
      if (stim_valid) begin
        n_stim <= n_stim + 16'h0001;
        stim_last <= stim_value;
      end
    end
  end
endmodule
`default_nettype wire

// >>> floating_gate_programmer_test.sv
// self-checking bench for the floating gate programming controller
`timescale 1ns/10ps
`default_nettype none
module floating_gate_programmer_test;
  import fg_prog_pkg::*;
  typedef struct {
    logic [2:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [9:0] pins;
  } row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ram_wr = 1'b0;
  logic [6:0] ram_wr_addr = 7'h00;
  logic [9:0] ram_wr_data = 10'h000;
  logic restart = 1'b1;
  logic [7:0] need = 8'h00;
  logic [31:0] reg_rdata, rd;
  logic [4:0] line_sel;
  logic [7:0] column_sel, n_verify, v_first, v_last, c_first, gap_min;
  logic readout_mode, cell_route_en, prog_up, prog_down, voltage_pulse, current_pulse;
  logic verify_sample, cell_reached, membrane_short, calib_en, stim_valid, irq;
  logic [3:0] upper_prog_bias, follower_bias;
  logic [9:0] stim_value, stim_last;
  logic [15:0] n_up, n_down, n_stim;
  int mismatches = 0;
  int comparisons = 0;
  row_t rows [7];
  always #20 sys_clk = ~sys_clk;
  fg_programmer uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ram_wr(ram_wr), .ram_wr_addr(ram_wr_addr), .ram_wr_data(ram_wr_data),
    .line_sel(line_sel), .column_sel(column_sel), .readout_mode(readout_mode),
    .cell_route_en(cell_route_en), .prog_up(prog_up), .prog_down(prog_down),
    .voltage_pulse(voltage_pulse), .current_pulse(current_pulse),
    .verify_sample(verify_sample), .cell_reached(cell_reached),
    .upper_prog_bias(upper_prog_bias), .follower_bias(follower_bias),
    .membrane_short(membrane_short), .calib_en(calib_en), .stim_value(stim_value),
    .stim_valid(stim_valid), .irq(irq));
  fg_array_model far (.sys_clk(sys_clk), .restart(restart), .need(need), .prog_up(prog_up),
    .prog_down(prog_down), .voltage_pulse(voltage_pulse), .current_pulse(current_pulse),
    .verify_sample(verify_sample), .cell_reached(cell_reached), .stim_valid(stim_valid),
    .stim_value(stim_value), .n_verify(n_verify), .n_up(n_up), .n_down(n_down),
    .v_first(v_first), .v_last(v_last), .c_first(c_first), .gap_min(gap_min),
    .n_stim(n_stim), .stim_last(stim_last));
  // ****************
  // tasks
  // ****************
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // polls busy, since a new instruction must not cut a run short
  task automatic wait_idle;
    int n;
    n = 0;
    rd = 32'h100;
    while (rd[busy_bit] !== 1'b0 && n < 3000) begin
      reg_read(result_addr, rd);
      n++;
    end
    chk_val({15'h0, rd[busy_bit]}, 16'h0000);
  endtask
  task automatic start_cmd(input logic [7:0] nd, input logic [31:0] cmd);
    @(posedge sys_clk);
    need <= nd;
    restart <= 1'b1;
    @(posedge sys_clk);
    restart <= 1'b0;
    reg_write(command_addr, cmd);
  endtask
  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    finish_test;
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    rows[0] = '{bias_addr, 32'hffff_ffff, 32'h0000_3fff, 10'h3ff};
    rows[1] = '{bias_addr, 32'h0000_2a5c, 32'h0000_2a5c, 10'h25c};
    rows[2] = '{timing_addr, 32'h8765_4321, 32'h8765_4321, 10'h25c};
    rows[3] = '{irq_mask_addr, 32'hffff_ffff, 32'h0000_0003, 10'h25c};
    rows[4] = '{3'h6, 32'hffff_ffff, 32'h0000_0000, 10'h25c};
    rows[5] = '{result_addr, 32'hffff_ffff, 32'h0000_0000, 10'h25c};
    rows[6] = '{bias_addr, 32'h0000_1093, 32'h0000_1093, 10'h193};
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    restart <= 1'b0;
    foreach (rows[i]) begin
      reg_write(rows[i].a, rows[i].d);
      reg_read(rows[i].a, rd);
      chk_reg(rd, rows[i].q);
      chk_val({6'h0, calib_en, membrane_short, follower_bias, upper_prog_bias}, {6'h0, rows[i].pins});
    end
    end_test("register rows");
    // short pulses keep the runs brief while still showing doubling
    reg_write(timing_addr, 32'h0c20_4203);
    reg_write(irq_mask_addr, 32'h0000_0002);
    start_cmd(8'h02, 32'h0000_4125);
    reg_read(result_addr, rd);
    chk_reg(rd & 32'h0000_0100, 32'h0000_0100);
    reg_read(command_addr, rd);
    chk_reg(rd, 32'h0000_4125);
    wait_idle;
    chk_reg(rd & 32'h0000_0300, 32'h0000_0000);
    chk_val({8'h0, n_verify}, 16'h0002);
    chk_val({14'h0, n_up != 16'h0, n_down == 16'h0}, 16'h0003);
    chk_val({15'h0, gap_min >= 8'h02}, 16'h0001);
    chk_val({3'h0, line_sel, column_sel}, 16'h0509);
    chk_val({15'h0, irq}, 16'h0000);
    reg_read(irq_status_addr, rd);
    chk_reg(rd, 32'h0000_0001);
    reg_write(irq_mask_addr, 32'h0000_0001);
    #1 chk_val({15'h0, irq}, 16'h0001);
    reg_write(irq_status_addr, 32'h0000_0001);
    #1 chk_val({15'h0, irq}, 16'h0000);
    end_test("program up");
    reg_write(irq_mask_addr, 32'h0000_0002);
    for (int r = 0; r < 2; r++) begin
      reg_write(bias_addr, 32'h0000_1093 | (32'(r) << 8));
      start_cmd(8'h00, 32'h0000_8167);
      wait_idle;
      chk_reg(rd, 32'h0000_020b);
      chk_val({8'h0, n_verify}, 16'h0003);
      chk_val({14'h0, n_down != 16'h0, n_up == 16'h0}, 16'h0003);
      chk_val({15'h0, v_last > v_first}, 16'h0001);
      if (r == 0) chk_val({v_first, c_first}, 16'h0203);
      else chk_val({15'h0, v_first > 8'h02}, 16'h0001);
    end
    chk_val({15'h0, irq}, 16'h0001);
    reg_read(irq_status_addr, rd);
    chk_reg(rd, 32'h0000_0003);
    reg_write(irq_status_addr, 32'h0000_0002);
    #1 chk_val({15'h0, irq}, 16'h0000);
    end_test("program down fail");
    start_cmd(8'h00, 32'h0000_c180);
    wait_idle;
    chk_reg(rd & 32'h0000_00ff, 32'h0000_000b);
    chk_val({8'h0, column_sel}, 16'h000b);
    end_test("find failed cell");
    for (int i = 0; i < 128; i++) begin
      @(posedge sys_clk);
      ram_wr <= 1'b1;
      ram_wr_addr <= 7'(i);
      ram_wr_data <= 10'(i + 1);
    end
    @(posedge sys_clk);
    ram_wr <= 1'b0;
    start_cmd(8'h00, 32'h0001_2000);
    wait_idle;
    chk_val(n_stim, 16'h0040);
    chk_val({6'h0, stim_last}, 16'h0080);
    end_test("single pass");
    start_cmd(8'h00, 32'h0001_4000);
    repeat (200) @(posedge sys_clk);
    chk_val({15'h0, n_stim > 16'h0040}, 16'h0001);
    reg_write(command_addr, 32'h0000_0083);
    start_cmd(8'h00, 32'h0000_0083);
    repeat (100) @(posedge sys_clk);
    chk_val(n_stim, 16'h0000);
    chk_val({14'h0, readout_mode, cell_route_en}, 16'h0003);
    chk_val({3'h0, line_sel, column_sel}, 16'h0304);
    reg_write(command_addr, 32'h0001_8000);
    repeat (4) @(posedge sys_clk);
    chk_val({14'h0, readout_mode, cell_route_en}, 16'h0000);
    end_test("continuous and readout");
    start_cmd(8'h00, 32'h0000_4125);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b0;
    #1 chk_val({12'h0, prog_up, prog_down, readout_mode, irq}, 16'h0000);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      reg_read(3'(a), rd);
      chk_reg(rd, 32'h0000_0000);
    end
    end_test("reset in mid-run");
    finish_test;
  end
endmodule
`default_nettype wire
